// *** hw/cue_command_validator_sequencer.sv ***
// Cue entry checker, cue store and high-speed playback sequencer
//
// Function
// - Only permitted combinations are ever issued
// - Invalid keypress is dropped, rest kept
// - Incomplete cue is refused and cleared
// - Home accepted only alone
// - Start/stop alone or with other commands
// - Start/stop refused with freeze or release
// - Wait codes accepted alone or summed
// - Shift turns waits into 3/10, 7/10, 2
// - Waits only time high-speed sections
// - Section runs automatically, max ten per second
// - One cue starts section, runs until stop or end of store
// - Different moves may be one tick apart
// - Three-projector mode rotates through three positions
// - Lamp swaps repeat with no added interval
// - Unshifted tray moves take selects and screens
// - Selects combine with dissolves plus screens
// - Shift remaps dissolve speeds
// - Lamp swap never advances trays
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module cue_command_validator_sequencer #(
    parameter int TICK_LEN = cue_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Keyboard pins
    input wire logic [4:0] key_code_in,
    input wire logic key_stb_in,
    // Projector drive
    output logic cue_stb_out,
    output logic [24:0] cue_word_out,
    output logic [2:0] lamp_on_out,
    output logic [2:0] advance_out,
    output logic running_out
);

    // ========================================
    // Command checking
    function automatic logic cmd_ok(input logic [24:0] c, input logic full);
        logic dis;
        logic tray;
        logic aux;
        logic wt;
        logic fr;
        logic scr;
        logic sh;
        logic [3:0] spd;
        logic [2:0] cat;
        logic ok;
        spd = c[cue_pkg::B_CUT:cue_pkg::B_D2];
        sh = c[cue_pkg::B_SHIFT];
        dis = (|spd) | c[cue_pkg::B_SWAP];
        tray = c[cue_pkg::B_FWD] | c[cue_pkg::B_REV];
        aux = c[cue_pkg::B_AUX];
        wt = |c[cue_pkg::B_W1:cue_pkg::B_W01];
        fr = c[cue_pkg::B_FREEZE] | c[cue_pkg::B_RELEASE];
        scr = |c[24:cue_pkg::B_SCR];
        cat = 3'(dis) + 3'(tray) + 3'(aux) + 3'(wt) + 3'(c[cue_pkg::B_HOME]) + 3'(fr);
        ok = (cat <= 3'h1) && (c != '0);
        // Speeds: single, or adjacent pair below cut when unshifted
        if (!(spd == 4'h0 || spd == 4'h1 || spd == 4'h2 || spd == 4'h4 || spd == 4'h8
              || (!sh && (spd == 4'h3 || spd == 4'h6))))
            ok = 1'b0;
        if (spd[3] && spd[2:0] != 3'h0)
            ok = 1'b0;
        if (tray && c[cue_pkg::B_FWD] && c[cue_pkg::B_REV])
            ok = 1'b0;
        if (tray && sh && (scr || (|c[cue_pkg::B_RIGHT:cue_pkg::B_LEFT])))
            ok = 1'b0;
        if (aux && (c[cue_pkg::B_CENTER] || (c[cue_pkg::B_LEFT] == c[cue_pkg::B_RIGHT])))
            ok = 1'b0;
        if (wt && (scr || (|c[cue_pkg::B_RIGHT:cue_pkg::B_LEFT])))
            ok = 1'b0;
        if (c[cue_pkg::B_HOME] && c != (25'h1 << cue_pkg::B_HOME))
            ok = 1'b0;
        if (fr && (c[cue_pkg::B_START] || c[cue_pkg::B_STOP]))
            ok = 1'b0;
        if (fr && c[cue_pkg::B_FREEZE] && c[cue_pkg::B_RELEASE])
            ok = 1'b0;
        if (full)
        begin
            if ((dis || aux || fr) && !scr)
                ok = 1'b0;
            if (tray && !sh && !scr)
                ok = 1'b0;
            if (cat == 3'h0 && !scr && !c[cue_pkg::B_START] && !c[cue_pkg::B_STOP])
                ok = 1'b0;
        end
        return ok;
    endfunction : cmd_ok

    // Wait total in ticks, shift remaps each code
    function automatic logic [5:0] wait_ticks(input logic [24:0] c);
        logic [5:0] t;
        t = 6'h0;
        if (c[cue_pkg::B_W01])
            t = t + {1'b0, c[cue_pkg::B_SHIFT] ? cue_pkg::TK_SW01 : cue_pkg::TK_W01};
        if (c[cue_pkg::B_W05])
            t = t + {1'b0, c[cue_pkg::B_SHIFT] ? cue_pkg::TK_SW05 : cue_pkg::TK_W05};
        if (c[cue_pkg::B_W1])
            t = t + {1'b0, c[cue_pkg::B_SHIFT] ? cue_pkg::TK_SW1 : cue_pkg::TK_W1};
        return t;
    endfunction : wait_ticks

    // ========================================
    // State
    logic [1:0] ctrl_r;
    logic [24:0] pend_r;
    logic [7:0] reject_r;
    logic [24:0] mem_r [cue_pkg::MEM_DEPTH];
    logic [3:0] wr_ptr_r;
    logic [3:0] rd_ptr_r;
    logic [3:0] sect_r;
    cue_pkg::play_state_e state_r;
    logic [5:0] ticks_r;
    logic [31:0] pre_r;
    logic [2:0] lit_r;
    logic [1:0] pos_r;
    logic [2:0] key_sync_r;
    logic [4:0] code_s1_r;
    logic [4:0] code_s2_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic cue_stb_r;
    logic [24:0] cue_word_r;
    logic [2:0] adv_r;
    logic running_r;

    // ========================================
    // Keyboard synchroniser and decode
    wire key_ev = key_sync_r[1] & ~key_sync_r[2];
    wire is_cmd_key = code_s2_r < cue_pkg::KEY_CUE;
    wire [24:0] key_bit = is_cmd_key ? (25'h1 << code_s2_r) : 25'h0;
    wire [24:0] cand = pend_r | key_bit;
    wire cand_ok = cmd_ok(cand, 1'b0);
    wire cue_key = key_ev && code_s2_r == cue_pkg::KEY_CUE;
    wire pend_full = cmd_ok(pend_r, 1'b1);
    wire play_mode = ctrl_r[cue_pkg::CTRL_PLAY];
    wire three_mode = ctrl_r[cue_pkg::CTRL_THREE];

    // ========================================
    // Playback decode
    wire [24:0] cur = mem_r[rd_ptr_r];
    wire at_end = rd_ptr_r == wr_ptr_r;
    wire cur_wait = |cur[cue_pkg::B_W1:cue_pkg::B_W01];
    wire [5:0] cur_ticks = wait_ticks(cur);
    wire tick = pre_r == 32'(TICK_LEN - 1);
    wire rec_cue = cue_key && !play_mode && pend_full;
    wire step_cue = cue_key && play_mode && state_r == cue_pkg::ST_IDLE && !at_end;
    wire run_issue = state_r == cue_pkg::ST_ISSUE && !at_end && !cur_wait;
    wire step_issue = step_cue && !cur[cue_pkg::B_START] && !cur_wait;
    wire issue = rec_cue || run_issue || step_issue;
    wire [24:0] icmd = rec_cue ? pend_r : cur;

    // ========================================
    // Lamp sequencing for the issued cue
    wire i_dis = (|icmd[cue_pkg::B_CUT:cue_pkg::B_D2]) | icmd[cue_pkg::B_SWAP];
    wire [2:0] i_lcr = icmd[cue_pkg::B_RIGHT:cue_pkg::B_LEFT];
    wire [1:0] pos_nxt = three_mode ? ((pos_r == 2'h2) ? 2'h0 : pos_r + 2'h1)
                                    : ((pos_r == 2'h0) ? 2'h1 : 2'h0);
    wire [2:0] lit_nxt = (i_lcr != 3'h0) ? (lit_r ^ i_lcr) : (3'h1 << pos_nxt);
    wire [2:0] down = lit_r & ~lit_nxt;
    wire [2:0] adv_nxt = (i_dis && !icmd[cue_pkg::B_SWAP]) ? down : 3'h0;

    // ========================================
    // APB decode
    wire apb_setup = psel_in && !penable_in;
    wire apb_acc = psel_in && penable_in && pready_r;
    wire addr_hit = paddr_in == cue_pkg::REG_CTRL || paddr_in == cue_pkg::REG_STATUS
                 || paddr_in == cue_pkg::REG_PENDING || paddr_in == cue_pkg::REG_REJECT;
    wire [31:0] status_word = {16'h0, wr_ptr_r, rd_ptr_r, 1'b0, lit_r, pos_r, state_r};
    wire [31:0] rd_mux = (paddr_in == cue_pkg::REG_CTRL) ? {30'h0, ctrl_r}
                       : (paddr_in == cue_pkg::REG_STATUS) ? status_word
                       : (paddr_in == cue_pkg::REG_PENDING) ? {7'h0, pend_r}
                       : (paddr_in == cue_pkg::REG_REJECT) ? {24'h0, reject_r}
                       : 32'h0;

    // ========================================
    // APB slave: answers one cycle after setup
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
            ctrl_r <= cue_pkg::CTRL_RST;
        end
        else
        begin
            pready_r <= apb_setup;
            pslverr_r <= apb_setup && !addr_hit;
            if (apb_setup && !pwrite_in)
                prdata_r <= rd_mux;
            if (apb_acc && pwrite_in && paddr_in == cue_pkg::REG_CTRL)
                ctrl_r <= pwdata_in[1:0];
        end
    end

    // ========================================
    // Keyboard capture
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            key_sync_r <= 3'h0;
            code_s1_r <= 5'h0;
            code_s2_r <= 5'h0;
        end
        else
        begin
            key_sync_r <= {key_sync_r[1:0], key_stb_in};
            code_s1_r <= key_code_in;
            code_s2_r <= code_s1_r;
        end
    end

    // ========================================
    // Pending entry
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pend_r <= 25'h0;
            reject_r <= 8'h0;
        end
        else if (key_ev && is_cmd_key)
        begin
            if (cand_ok)
                pend_r <= cand;
            else
                reject_r <= reject_r + 8'h1;
        end
        else if (cue_key || (key_ev && code_s2_r == cue_pkg::KEY_CLEAR))
        begin
            pend_r <= 25'h0;
            if (cue_key && !play_mode && !pend_full)
                reject_r <= reject_r + 8'h1;
        end
    end

    // ========================================
    // Cue store
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            wr_ptr_r <= 4'h0;
        else if (rec_cue)
        begin
            mem_r[wr_ptr_r] <= pend_r;
            wr_ptr_r <= wr_ptr_r + 4'h1;
        end
    end

    // ========================================
    // Tenth-second prescaler
    always_ff @(posedge clk_in)
    begin
        if (rst_in || state_r != cue_pkg::ST_WAIT || tick)
            pre_r <= 32'h0;
        else
            pre_r <= pre_r + 32'h1;
    end

    // ========================================
    // Playback sequencer
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state_r <= cue_pkg::ST_IDLE;
            rd_ptr_r <= 4'h0;
            sect_r <= 4'h0;
            ticks_r <= 6'h0;
        end
        else if (key_ev && code_s2_r == cue_pkg::KEY_REWIND && play_mode)
        begin
            state_r <= cue_pkg::ST_IDLE;
            rd_ptr_r <= sect_r;
        end
        else
        begin
            case (state_r)
                cue_pkg::ST_IDLE:
                begin
                    if (step_cue)
                    begin
                        if (cur[cue_pkg::B_START])
                        begin
                            sect_r <= rd_ptr_r;
                            state_r <= cue_pkg::ST_ISSUE;
                        end
                        else
                            rd_ptr_r <= rd_ptr_r + 4'h1;
                    end
                end
                cue_pkg::ST_ISSUE:
                begin
                    if (at_end)
                        state_r <= cue_pkg::ST_IDLE;
                    else if (cur_wait)
                    begin
                        rd_ptr_r <= rd_ptr_r + 4'h1;
                        if (cur_ticks > 6'h1)
                        begin
                            ticks_r <= cur_ticks - 6'h1;
                            state_r <= cue_pkg::ST_WAIT;
                        end
                    end
                    else
                    begin
                        rd_ptr_r <= rd_ptr_r + 4'h1;
                        ticks_r <= 6'h1;
                        state_r <= cur[cue_pkg::B_STOP] ? cue_pkg::ST_IDLE
                                                        : cue_pkg::ST_WAIT;
                    end
                end
                cue_pkg::ST_WAIT:
                begin
                    if (tick)
                    begin
                        if (ticks_r <= 6'h1)
                            state_r <= cue_pkg::ST_ISSUE;
                        else
                            ticks_r <= ticks_r - 6'h1;
                    end
                end
                default:
                    state_r <= cue_pkg::ST_IDLE;
            endcase
        end
    end

    // ========================================
    // Projector drive
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cue_stb_r <= 1'b0;
            cue_word_r <= 25'h0;
            adv_r <= 3'h0;
            lit_r <= 3'h0;
            pos_r <= 2'h2;
            running_r <= 1'b0;
        end
        else
        begin
            cue_stb_r <= issue;
            adv_r <= issue ? adv_nxt : 3'h0;
            running_r <= state_r != cue_pkg::ST_IDLE;
            if (issue)
                cue_word_r <= icmd;
            if (issue && i_dis)
            begin
                lit_r <= lit_nxt;
                if (i_lcr == 3'h0)
                    pos_r <= pos_nxt;
            end
        end
    end

    // ========================================
    // Outputs
    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign cue_stb_out = cue_stb_r;
    assign cue_word_out = cue_word_r;
    assign lamp_on_out = lit_r;
    assign advance_out = adv_r;
    assign running_out = running_r;

endmodule : cue_command_validator_sequencer

// *** hw/cue_pkg.sv ***
// Shared constants for the cue validator and sequencer
package cue_pkg;

    // ========================================
    // Command word bit positions
    localparam int CMD_W = 25;
    localparam int B_D2 = 0;
    localparam int B_D4 = 1;
    localparam int B_D8 = 2;
    localparam int B_CUT = 3;
    localparam int B_SWAP = 4;
    localparam int B_SHIFT = 5;
    localparam int B_LEFT = 6;
    localparam int B_CENTER = 7;
    localparam int B_RIGHT = 8;
    localparam int B_FWD = 9;
    localparam int B_REV = 10;
    localparam int B_AUX = 11;
    localparam int B_START = 12;
    localparam int B_STOP = 13;
    localparam int B_HOME = 14;
    localparam int B_W01 = 15;
    localparam int B_W05 = 16;
    localparam int B_W1 = 17;
    localparam int B_FREEZE = 18;
    localparam int B_RELEASE = 19;
    localparam int B_SCR = 20;

    // ========================================
    // Key codes beyond the command bits
    localparam logic [4:0] KEY_CUE = 5'h19;
    localparam logic [4:0] KEY_REWIND = 5'h1a;
    localparam logic [4:0] KEY_CLEAR = 5'h1b;

    // ========================================
    // Wait codes in tenths of a second
    localparam logic [4:0] TK_W01 = 5'h01;
    localparam logic [4:0] TK_W05 = 5'h05;
    localparam logic [4:0] TK_W1 = 5'h0a;
    localparam logic [4:0] TK_SW01 = 5'h03;
    localparam logic [4:0] TK_SW05 = 5'h07;
    localparam logic [4:0] TK_SW1 = 5'h14;

    // ========================================
    // Timing
    localparam int CLK_HZ = 25000000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    // ========================================
    // Register map and reset values
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_PENDING = 8'h08;
    localparam logic [7:0] REG_REJECT = 8'h0c;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int CTRL_THREE = 0;
    localparam int CTRL_PLAY = 1;

    // ========================================
    // Cue store
    localparam int MEM_DEPTH = 16;
    localparam int PTR_W = 4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT = 2'b10
    } play_state_e;

endpackage : cue_pkg

// *** tb/cue_command_validator_sequencer_asserts.sv ***
// Port checker for the cue validator and sequencer
`timescale 1ns/100ps
module cue_checker #(
    parameter int TICK_LEN = 10
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [7:0] paddr_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic cue_stb_out,
    input wire logic [24:0] cue_word_out,
    input wire logic [2:0] advance_out,
    input wire logic running_out
);
    // ========================================
    // Cycles since the last issued cue
    logic [31:0] gap_r;
    logic mapped;
    assign mapped = paddr_in inside {cue_pkg::REG_CTRL, cue_pkg::REG_STATUS,
        cue_pkg::REG_PENDING, cue_pkg::REG_REJECT};
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            gap_r <= 32'hffffffff;
        else if (cue_stb_out)
            gap_r <= 32'h0;
        else if (gap_r != 32'hffffffff)
            gap_r <= gap_r + 32'h1;
    end

    // ========================================
    // Properties
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_swap_cue;
        cue_stb_out && cue_word_out[cue_pkg::B_SWAP];
    endsequence
    sequence s_marker_cue;
        cue_stb_out && (cue_word_out[cue_pkg::B_START] || cue_word_out[cue_pkg::B_STOP]);
    endsequence

    chk_apb_answer: assert property (s_setup |=> pready_out)
        else $error("no ready after setup");
    chk_pready_single: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    chk_err_unmapped: assert property (pready_out |-> pslverr_out == !mapped)
        else $error("slave error wrong for address");
    chk_adv_cause: assert property (advance_out != 3'h0 |-> cue_stb_out)
        else $error("tray advance without cue");
    chk_swap_trays: assert property (s_swap_cue |-> advance_out == 3'h0)
        else $error("lamp swap advanced trays");
    chk_home_alone: assert property (cue_stb_out && cue_word_out[cue_pkg::B_HOME]
        |-> cue_word_out == (25'h1 << cue_pkg::B_HOME))
        else $error("home issued with other keys");
    chk_marker_freeze: assert property (s_marker_cue
        |-> !cue_word_out[cue_pkg::B_FREEZE] && !cue_word_out[cue_pkg::B_RELEASE])
        else $error("marker issued with freeze or release");
    chk_cue_spacing: assert property (cue_stb_out && running_out
        |-> gap_r >= 32'(TICK_LEN - 1))
        else $error("playback cues closer than one tick");
endmodule : cue_checker

bind cue_command_validator_sequencer cue_checker #(.TICK_LEN(TICK_LEN)) i_cue_checker (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .paddr_in(paddr_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .cue_stb_out(cue_stb_out), .cue_word_out(cue_word_out),
    .advance_out(advance_out), .running_out(running_out));

// *** tb/op_panel_model.sv ***
// Operator keyboard and projector-side cue monitor
`timescale 1ns/100ps
module op_panel_model (
    // Clock
    input wire logic clk_in,
    // Keyboard pins
    output logic [4:0] key_code_out,
    output logic key_stb_out,
    // Projector drive
    input wire logic cue_stb_in,
    input wire logic [24:0] cue_word_in,
    input wire logic [2:0] advance_in
);
    int stb_cnt = 0;
    int cyc = 0;
    int last_cyc = 0;
    int gap = 0;
    logic [24:0] last_word = 25'h0;
    logic [2:0] last_adv = 3'h0;

    initial
    begin
        key_code_out = 5'h00;
        key_stb_out = 1'b0;
    end

    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cue_stb_in === 1'b1)
        begin
            stb_cnt <= stb_cnt + 1;
            gap <= cyc - last_cyc;
            last_cyc <= cyc;
            last_word <= cue_word_in;
            last_adv <= advance_in;
        end
    end

    // One keypress, code held well around the strobe edge
    task automatic press(input logic [4:0] c);
        key_code_out <= c;
        @(posedge clk_in);
        key_stb_out <= 1'b1;
        repeat (6) @(posedge clk_in);
        key_stb_out <= 1'b0;
        key_code_out <= ~c;
        repeat (6) @(posedge clk_in);
    endtask : press
endmodule : op_panel_model

// *** tb/tb_cue_command_validator_sequencer.sv ***
// Self-checking bench for the cue validator and sequencer
`timescale 1ns/100ps
module tb_cue_command_validator_sequencer;
    localparam int TL = 10;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic [4:0] key_code_in;
    logic key_stb_in;
    logic cue_stb_out;
    logic [24:0] cue_word_out;
    logic [2:0] lamp_on_out;
    logic [2:0] advance_out;
    logic running_out;
    logic [31:0] q;
    logic e;
    int failures = 0;
    int num_checks = 0;

    always #20 clk_in = ~clk_in;

    cue_command_validator_sequencer #(.TICK_LEN(TL)) i_cue_command_validator_sequencer (
        .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .key_code_in(key_code_in), .key_stb_in(key_stb_in), .cue_stb_out(cue_stb_out),
        .cue_word_out(cue_word_out), .lamp_on_out(lamp_on_out),
        .advance_out(advance_out), .running_out(running_out));
    op_panel_model i_op_panel_model (.clk_in(clk_in), .key_code_out(key_code_in),
        .key_stb_out(key_stb_in), .cue_stb_in(cue_stb_out), .cue_word_in(cue_word_out),
        .advance_in(advance_out));

    // ========================================
    // Shared tasks
    task automatic end_of_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic tmo(input int n, input int lim);
        if (n >= lim)
        begin
            failures++;
            $display("BAD %0t wait ran out", $time);
            end_of_test();
        end
    endtask : tmo

    function automatic logic [24:0] bw(input int k);
        return 25'h1 << k;
    endfunction : bw

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        @(posedge clk_in);
        while (pready_out !== 1'b1 && n < 50)
        begin
            @(posedge clk_in);
            n++;
        end
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
        tmo(n, 50);
    endtask : apb

    task automatic key(input int k);
        i_op_panel_model.press(5'(k));
    endtask : key

    task automatic enter(input logic [24:0] w);
        for (int i = 0; i < 25; i++)
            if (w[i])
                key(i);
        key(cue_pkg::KEY_CUE);
    endtask : enter

    // ========================================
    // Scenarios
    task automatic t_regs;
        apb(1'b0, cue_pkg::REG_CTRL, 32'h0);
        chk(q, 32'h0, "ctrl reset");
        apb(1'b1, cue_pkg::REG_CTRL, 32'hffffffff);
        apb(1'b0, cue_pkg::REG_CTRL, 32'h0);
        chk(q, 32'h3, "ctrl rw");
        apb(1'b1, cue_pkg::REG_CTRL, 32'h0);
        apb(1'b1, cue_pkg::REG_STATUS, 32'h5);
        apb(1'b0, cue_pkg::REG_STATUS, 32'h0);
        // Lamp position resets to the last slot
        chk(q, 32'h8, "status ro");
        apb(1'b0, 8'h10, 32'h0);
        chk({q[30:0], e}, 32'h1, "unmapped");
    endtask : t_regs

    task automatic t_valid;
        int t [7][3];
        logic [24:0] w;
        int lamp_exp [7];
        int adv_exp [7];
        int n;
        t = '{'{cue_pkg::B_D2, cue_pkg::B_SCR, cue_pkg::B_SCR + 1},
            '{cue_pkg::B_SHIFT, cue_pkg::B_D8, cue_pkg::B_SCR + 1},
            '{cue_pkg::B_FWD, cue_pkg::B_LEFT, cue_pkg::B_SCR + 2},
            '{cue_pkg::B_REV, cue_pkg::B_RIGHT, cue_pkg::B_SCR + 4},
            '{cue_pkg::B_CUT, cue_pkg::B_CENTER, cue_pkg::B_SCR + 3},
            '{cue_pkg::B_SWAP, cue_pkg::B_SCR, cue_pkg::B_SCR},
            '{cue_pkg::B_HOME, cue_pkg::B_HOME, cue_pkg::B_HOME}};
        lamp_exp = '{1, 2, 2, 2, 0, 1, 1};
        adv_exp = '{0, 1, 0, 0, 2, 0, 0};
        for (int i = 0; i < 7; i++)
        begin
            w = bw(t[i][0]) | bw(t[i][1]) | bw(t[i][2]);
            n = i_op_panel_model.stb_cnt;
            enter(w);
            chk(i_op_panel_model.stb_cnt - n, 1, "cue issued");
            chk(i_op_panel_model.last_word, w, "cue word");
            chk(lamp_on_out, lamp_exp[i], "lamp state");
            chk(i_op_panel_model.last_adv, adv_exp[i], "tray advance");
            if (w[cue_pkg::B_SWAP])
                chk(i_op_panel_model.last_adv, 3'h0, "swap advance");
        end
    endtask : t_valid

    task automatic t_bad;
        int n;
        n = i_op_panel_model.stb_cnt;
        key(cue_pkg::B_D2);
        key(cue_pkg::B_SCR);
        key(cue_pkg::B_HOME);
        apb(1'b0, cue_pkg::REG_PENDING, 32'h0);
        chk(q, bw(cue_pkg::B_D2) | bw(cue_pkg::B_SCR), "kept part");
        key(cue_pkg::KEY_CLEAR);
        key(cue_pkg::B_START);
        key(cue_pkg::B_FREEZE);
        apb(1'b0, cue_pkg::REG_PENDING, 32'h0);
        chk(q, bw(cue_pkg::B_START), "marker kept");
        key(cue_pkg::KEY_CLEAR);
        key(cue_pkg::B_D2);
        key(cue_pkg::KEY_CUE);
        apb(1'b0, cue_pkg::REG_PENDING, 32'h0);
        chk(q, 32'h0, "incomplete cleared");
        apb(1'b0, cue_pkg::REG_REJECT, 32'h0);
        chk(q, 32'h3, "reject count");
        chk(i_op_panel_model.stb_cnt - n, 0, "nothing issued");
    endtask : t_bad

    task automatic t_play;
        int n;
        int i;
        logic [24:0] fin;
        fin = bw(cue_pkg::B_SWAP) | bw(cue_pkg::B_SCR) | bw(cue_pkg::B_STOP);
        enter(bw(cue_pkg::B_START) | bw(cue_pkg::B_D2) | bw(cue_pkg::B_SCR));
        enter(bw(cue_pkg::B_SHIFT) | bw(cue_pkg::B_W01) | bw(cue_pkg::B_W05));
        enter(fin);
        apb(1'b1, cue_pkg::REG_CTRL, 32'h3);
        key(cue_pkg::KEY_REWIND);
        // Step through the seven cues stored ahead of the section
        n = i_op_panel_model.stb_cnt;
        for (i = 0; i < 7; i++)
            key(cue_pkg::KEY_CUE);
        chk(i_op_panel_model.stb_cnt - n, 7, "step cues");
        n = i_op_panel_model.stb_cnt;
        key(cue_pkg::KEY_CUE);
        for (i = 0; i < 2000 && i_op_panel_model.stb_cnt - n < 2; i++)
            @(posedge clk_in);
        tmo(i, 2000);
        n = i_op_panel_model.gap;
        chk(n >= 10 * TL && n <= 10 * TL + 3, 1, "summed shifted wait");
        for (i = 0; i < 200 && running_out !== 1'b0; i++)
            @(posedge clk_in);
        tmo(i, 200);
        chk(running_out, 1'b0, "section ended");
        key(cue_pkg::KEY_REWIND);
        n = i_op_panel_model.stb_cnt;
        key(cue_pkg::KEY_CUE);
        for (i = 0; i < 2000 && i_op_panel_model.stb_cnt - n < 2; i++)
            @(posedge clk_in);
        tmo(i, 2000);
        chk(i_op_panel_model.last_word, fin, "rewound section");
    endtask : t_play

    initial
    begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        t_regs();
        t_valid();
        t_bad();
        t_play();
        end_of_test();
    end
endmodule : tb_cue_command_validator_sequencer
